// ---- src/mmsp_meter.sv ----
// Decided for this implementation: the strobed register port.
`default_nettype none
// Notes on behaviour
// [R1] Link 19200 8N1, seven-character frame gap.
// [R2] Slave address from serial number's last digits.
// [R3] Function 03 reads answered with reply frame.
// [R4] Floats sent as bytes 1, 0, 3, 2.
// [R5] 32-bit integers use same word-swapped order.
// [R6] 16-bit values high byte first.
// [R7] MSB-first master reorders to bytes 3-2-1-0.
// [R8] LSB-first master reorders to bytes 0-1-2-3.
// [R9] One pulse per whole consumption unit.
// [R10] Volume summed per second, pulsed afterwards.
// [R11] Pulse 120, 60 or 30 ms by flow.
// [R12] At most sixteen meters per segment.
// [R13] Linear daisy chain, no ring or star.
// [R14] Wrong address or bad CRC: no reply.
// [R15] Master waits one second; no reply delay.
module mmsp_meter #(
   parameter int BIT_CYC = mmsp_pkg::BIT_CYC,
   parameter int GAP_CYC = mmsp_pkg::GAP_CYC,
   parameter int SECOND_CYC = mmsp_pkg::SECOND_CYC,
   parameter int PULSE_LONG_CYC = mmsp_pkg::PULSE_LONG_CYC,
   parameter int PULSE_MID_CYC = mmsp_pkg::PULSE_MID_CYC,
   parameter int PULSE_SHORT_CYC = mmsp_pkg::PULSE_SHORT_CYC
) (
   // System
   input wire logic clk,
   input wire logic srst,
   // Bus side
   mmsp_link_if.meter link,
   // Serial number, last two decimal digits
   input wire logic [3:0] serialTens,
   input wire logic [3:0] serialOnes,
   // Measurements
   input wire logic [31:0] pressureIn,
   input wire logic [31:0] flowIn,
   input wire logic [15:0] flowM3s,
   input wire logic [15:0] volUnits,
   input wire logic volValid,
   // Pulse output and own state
   output logic pulseSwitchOutput,
   output logic [7:0] slaveAddr,
   output logic [31:0] totalCount
);
   import mmsp_pkg::*;
   typedef enum logic [1:0] {ST_IDLE, ST_LOAD, ST_WAIT} mmsp_reply_t;
   mmsp_reply_t st_r;
   logic txStart_r, txBusy, rxValid, rxGap, addrLoad_r, reqOk;
   logic [7:0] txData_r, rxData, seq_r, last_r, qty_r, byteNxt, dataIdx;
   logic [7:0] reqBuf_r [REQ_LEN];
   logic [3:0] reqCnt_r;
   logic [15:0] rxCrc_r, txCrc_r, start_r, reqStart, reqQty, wAddr, word;
   logic [31:0] snapPress_r, snapFlow_r, snapCons_r;

   mmsp_uart #(.BIT_CYC(BIT_CYC), .GAP_CYC(GAP_CYC)) uart (
      .clk(clk),
      .srst(srst),
      .rxPin(link.line),
      .txPin(link.devTx),
      .txOeN(link.devOeN),
      .txStart(txStart_r),
      .txData(txData_r),
      .txBusy(txBusy),
      .rxValid(rxValid),
      .rxData(rxData),
      .rxGap(rxGap)
   );

   // Straps caught one edge after release
   always_ff @(posedge clk) begin
      if (srst) begin
         addrLoad_r <= 1'b1;
         slaveAddr <= 8'h00;
      end else if (addrLoad_r) begin
         addrLoad_r <= 1'b0;
         slaveAddr <= 8'({serialTens, 3'h0}) + 8'({serialTens, 1'h0}) + {4'h0, serialOnes}; // [R2]
      end
   end

   // Request collection
   always_ff @(posedge clk) begin
      if (srst) begin
         reqCnt_r <= 4'h0;
         rxCrc_r <= CRC_INIT;
      end else if (rxGap) begin
         reqCnt_r <= 4'h0; // [R1]
         rxCrc_r <= CRC_INIT;
      end else if (rxValid && !txBusy && st_r == ST_IDLE) begin
         if (reqCnt_r < 4'(REQ_LEN))
            reqBuf_r[reqCnt_r[2:0]] <= rxData;
         if (reqCnt_r <= 4'(REQ_LEN))
            reqCnt_r <= reqCnt_r + 4'h1;
         rxCrc_r <= crcStep(rxCrc_r, rxData);
      end
   end

   assign reqStart = {reqBuf_r[2], reqBuf_r[3]};
   assign reqQty = {reqBuf_r[4], reqBuf_r[5]};
   // Anything but an exact, addressed, intact read is dropped silently
   assign reqOk = rxGap && st_r == ST_IDLE && reqCnt_r == 4'(REQ_LEN)
      && rxCrc_r == CRC_RESIDUE && reqBuf_r[0] == slaveAddr // [R14]
      && reqBuf_r[1] == FN_READ_HOLD && reqQty != 16'h0000 && reqQty <= MAX_QTY; // [R3]

   // Reply byte source
   always_comb begin
      dataIdx = seq_r - 8'(HEAD_LEN);
      wAddr = start_r + {9'h000, dataIdx[7:1]};
      case (wAddr)
         REG_PRESSURE: word = snapPress_r[15:0]; // [R4]
         REG_PRESSURE + 16'h0001: word = snapPress_r[31:16];
         REG_FLOW: word = snapFlow_r[15:0];
         REG_FLOW + 16'h0001: word = snapFlow_r[31:16];
         REG_CONSUMPTION: word = snapCons_r[15:0]; // [R5]
         REG_CONSUMPTION + 16'h0001: word = snapCons_r[31:16];
         default: word = 16'h0000;
      endcase
      if (seq_r == 8'h00)
         byteNxt = slaveAddr;
      else if (seq_r == 8'h01)
         byteNxt = FN_READ_HOLD;
      else if (seq_r == 8'h02)
         byteNxt = {qty_r[6:0], 1'h0};
      else if (seq_r == last_r - 8'h01)
         byteNxt = txCrc_r[7:0];
      else if (seq_r == last_r)
         byteNxt = txCrc_r[15:8];
      else
         byteNxt = dataIdx[0] ? word[7:0] : word[15:8]; // [R6]
   end

   // Reply sequencer
   always_ff @(posedge clk) begin
      if (srst) begin
         st_r <= ST_IDLE;
         txStart_r <= 1'b0;
         txData_r <= 8'h00;
         seq_r <= 8'h00;
         last_r <= 8'h00;
         qty_r <= 8'h00;
         start_r <= 16'h0000;
         txCrc_r <= CRC_INIT;
         snapPress_r <= 32'h0000_0000;
         snapFlow_r <= 32'h0000_0000;
         snapCons_r <= 32'h0000_0000;
      end else begin
         txStart_r <= 1'b0;
         case (st_r)
            ST_IDLE: begin
               if (reqOk) begin
                  // Snapshot keeps both words of a value coherent
                  snapPress_r <= pressureIn;
                  snapFlow_r <= flowIn;
                  snapCons_r <= totalCount;
                  start_r <= reqStart;
                  qty_r <= reqQty[7:0];
                  seq_r <= 8'h00;
                  last_r <= 8'(HEAD_LEN + 1) + {reqQty[6:0], 1'h0};
                  txCrc_r <= CRC_INIT;
                  st_r <= ST_LOAD; // [R15]
               end
            end
            ST_LOAD: begin
               txStart_r <= 1'b1;
               txData_r <= byteNxt;
               if (seq_r < last_r - 8'h01)
                  txCrc_r <= crcStep(txCrc_r, byteNxt);
               st_r <= ST_WAIT;
            end
            ST_WAIT: begin
               if (!txStart_r && !txBusy) begin
                  if (seq_r == last_r) begin
                     st_r <= ST_IDLE;
                  end else begin
                     seq_r <= seq_r + 8'h01;
                     st_r <= ST_LOAD;
                  end
               end
            end
            default: st_r <= ST_IDLE;
         endcase
      end
   end

   // Pulse generator
   logic [31:0] secCyc_r, volAcc_r, pending_r, pulseCyc_r, pulseLen_r;
   logic pulseActive_r, secEnd, pulseStart;
   assign secEnd = secCyc_r == 32'(SECOND_CYC - 1);
   assign pulseStart = !pulseActive_r && pending_r != 32'h0000_0000;

   always_ff @(posedge clk) begin
      if (srst) begin
         secCyc_r <= 32'h0000_0000;
         volAcc_r <= 32'h0000_0000;
         totalCount <= 32'h0000_0000;
      end else begin
         secCyc_r <= secEnd ? 32'h0000_0000 : secCyc_r + 32'h0000_0001;
         if (secEnd) begin
            // Volume in the closing cycle opens the next second
            volAcc_r <= volValid ? {16'h0000, volUnits} : 32'h0000_0000; // [R10]
            totalCount <= totalCount + volAcc_r;
         end else if (volValid) begin
            volAcc_r <= volAcc_r + {16'h0000, volUnits};
         end
      end
   end

   always_ff @(posedge clk) begin
      if (srst)
         pending_r <= 32'h0000_0000;
      else
         pending_r <= pending_r + (secEnd ? volAcc_r : 32'h0000_0000)
            - (pulseStart ? 32'h0000_0001 : 32'h0000_0000); // [R9]
   end

   // Off time is on time plus one cycle, so pulses stay countable
   always_ff @(posedge clk) begin
      if (srst) begin
         pulseActive_r <= 1'b0;
         pulseSwitchOutput <= 1'b0;
         pulseCyc_r <= 32'h0000_0000;
         pulseLen_r <= 32'h0000_0000;
      end else if (pulseStart) begin
         pulseActive_r <= 1'b1;
         pulseSwitchOutput <= 1'b1; // [R9]
         pulseCyc_r <= 32'h0000_0000;
         if (flowM3s > FLOW_HIGH_M3S)
            pulseLen_r <= 32'(PULSE_SHORT_CYC); // [R11]
         else if (flowM3s > FLOW_MID_M3S)
            pulseLen_r <= 32'(PULSE_MID_CYC);
         else
            pulseLen_r <= 32'(PULSE_LONG_CYC);
      end else if (pulseActive_r) begin
         pulseCyc_r <= pulseCyc_r + 32'h0000_0001;
         if (pulseCyc_r == pulseLen_r - 32'h0000_0001)
            pulseSwitchOutput <= 1'b0;
         if (pulseCyc_r == {pulseLen_r[30:0], 1'h0} - 32'h0000_0001)
            pulseActive_r <= 1'b0;
      end
   end
endmodule
`default_nettype wire

// ---- src/mmsp_pkg.sv ----
`default_nettype none
package mmsp_pkg;
   // Timing
   localparam int CLK_HZ = 25_000_000;
   localparam int BAUD = 19200;
   localparam int BIT_CYC = CLK_HZ / BAUD;
   localparam int CHAR_BITS = 10;
   localparam int GAP_CHARS = 7;
   localparam int GAP_CYC = GAP_CHARS * CHAR_BITS * BIT_CYC;
   localparam int MS_CYC = CLK_HZ / 1000;
   localparam int SECOND_MS = 1000;
   localparam int SECOND_CYC = SECOND_MS * MS_CYC;
   localparam int TIMEOUT_MS = 1000;
   localparam int TIMEOUT_CYC = TIMEOUT_MS * MS_CYC;
   localparam int PULSE_LONG_MS = 120;
   localparam int PULSE_MID_MS = 60;
   localparam int PULSE_SHORT_MS = 30;
   localparam int PULSE_LONG_CYC = PULSE_LONG_MS * MS_CYC;
   localparam int PULSE_MID_CYC = PULSE_MID_MS * MS_CYC;
   localparam int PULSE_SHORT_CYC = PULSE_SHORT_MS * MS_CYC;
   localparam logic [15:0] FLOW_MID_M3S = 16'h0003;
   localparam logic [15:0] FLOW_HIGH_M3S = 16'h0006;
   // Protocol
   localparam logic [7:0] FN_READ_HOLD = 8'h03;
   localparam int REQ_LEN = 8;
   localparam int HEAD_LEN = 3;
   localparam logic [15:0] MAX_QTY = 16'h007D;
   localparam logic [15:0] CRC_INIT = 16'hFFFF;
   localparam logic [15:0] CRC_POLY = 16'hA001;
   localparam logic [15:0] CRC_RESIDUE = 16'h0000;
   // Measurement word addresses, low word first
   localparam logic [15:0] REG_PRESSURE = 16'h0002;
   localparam logic [15:0] REG_FLOW = 16'h0006;
   localparam logic [15:0] REG_CONSUMPTION = 16'h0008;
   // Master software port
   localparam logic [4:0] SW_SLAVE = 5'h00;
   localparam logic [4:0] SW_START = 5'h04;
   localparam logic [4:0] SW_QTY = 5'h08;
   localparam logic [4:0] SW_GO = 5'h0C;
   localparam logic [4:0] SW_STATUS = 5'h10;
   localparam logic [4:0] SW_DATA_MSB = 5'h14;
   localparam logic [4:0] SW_DATA_LSB = 5'h18;
   localparam int ST_BUSY = 0;
   localparam int ST_DONE = 1;
   localparam int ST_TIMEOUT = 2;
   localparam int ST_BADREPLY = 3;
   localparam logic [7:0] DEF_SLAVE = 8'h01;
   localparam logic [7:0] DEF_QTY = 8'h02;

   function automatic logic [15:0] crcStep(input logic [15:0] crc, input logic [7:0] b);
      logic [15:0] c;
      c = crc ^ {8'h00, b};
      for (int i = 0; i < 8; i++) begin
         c = c[0] ? ((c >> 1) ^ CRC_POLY) : (c >> 1);
      end
      return c;
   endfunction
endpackage
`default_nettype wire

// ---- src/mmsp_link_if.sv ----
`default_nettype none
interface mmsp_link_if;
   logic devTx;
   logic devOeN;
   logic mstTx;
   logic mstOeN;
   logic line;
   // Biased idle high when nobody drives
   assign line = !devOeN ? devTx : (!mstOeN ? mstTx : 1'b1);
   modport meter (output devTx, output devOeN, input line);
   modport master (output mstTx, output mstOeN, input line);
endinterface
`default_nettype wire

// ---- src/mmsp_uart.sv ----
`default_nettype none
module mmsp_uart #(
   parameter int BIT_CYC = mmsp_pkg::BIT_CYC,
   parameter int GAP_CYC = mmsp_pkg::GAP_CYC
) (
   // System
   input wire logic clk,
   input wire logic srst,
   // Line
   input wire logic rxPin,
   output logic txPin,
   output logic txOeN,
   // Byte side
   input wire logic txStart,
   input wire logic [7:0] txData,
   output logic txBusy,
   output logic rxValid,
   output logic [7:0] rxData,
   output logic rxGap
);
   import mmsp_pkg::*;
   localparam int HALF_CYC = BIT_CYC / 2;
   logic rxMeta_r, rxSync_r, rxBusy_r, seen_r;
   logic [8:0] txShift_r;
   logic [3:0] txBits_r, rxBits_r;
   logic [15:0] txCyc_r, rxCyc_r;
   logic [7:0] rxShift_r;
   logic [31:0] gapCyc_r;

   always_ff @(posedge clk) begin
      if (srst) begin
         rxMeta_r <= 1'b1;
         rxSync_r <= 1'b1;
      end else begin
         rxMeta_r <= rxPin;
         rxSync_r <= rxMeta_r;
      end
   end

   // Start, 8 data LSB first, stop, no parity
   always_ff @(posedge clk) begin
      if (srst) begin
         txPin <= 1'b1;
         txOeN <= 1'b1;
         txBusy <= 1'b0;
         txShift_r <= 9'h1FF;
         txBits_r <= 4'h0;
         txCyc_r <= 16'h0000;
      end else if (!txBusy) begin
         if (txStart) begin
            txBusy <= 1'b1;
            txOeN <= 1'b0;
            txPin <= 1'b0;
            txShift_r <= {1'b1, txData};
            txBits_r <= 4'h0;
            txCyc_r <= 16'h0000;
         end
      end else if (txCyc_r != 16'(BIT_CYC - 1)) begin
         txCyc_r <= txCyc_r + 16'h0001;
      end else begin
         txCyc_r <= 16'h0000;
         txBits_r <= txBits_r + 4'h1;
         if (txBits_r == 4'(CHAR_BITS - 1)) begin
            txBusy <= 1'b0;
            txOeN <= 1'b1;
            txPin <= 1'b1;
         end else begin
            txPin <= txShift_r[0];
            txShift_r <= {1'b1, txShift_r[8:1]};
         end
      end
   end

   // Sample mid-bit
   always_ff @(posedge clk) begin
      if (srst) begin
         rxBusy_r <= 1'b0;
         rxCyc_r <= 16'h0000;
         rxBits_r <= 4'h0;
         rxShift_r <= 8'h00;
         rxValid <= 1'b0;
         rxData <= 8'h00;
      end else begin
         rxValid <= 1'b0;
         if (!rxBusy_r) begin
            if (!rxSync_r) begin
               rxBusy_r <= 1'b1;
               rxCyc_r <= 16'(HALF_CYC - 1);
               rxBits_r <= 4'h0;
            end
         end else if (rxCyc_r != 16'h0000) begin
            rxCyc_r <= rxCyc_r - 16'h0001;
         end else begin
            rxCyc_r <= 16'(BIT_CYC - 1);
            rxBits_r <= rxBits_r + 4'h1;
            if (rxBits_r == 4'h0 && rxSync_r) begin
               rxBusy_r <= 1'b0;
            end else if (rxBits_r == 4'(CHAR_BITS - 1)) begin
               rxBusy_r <= 1'b0;
               rxValid <= rxSync_r;
               rxData <= rxShift_r;
            end else begin
               rxShift_r <= {rxSync_r, rxShift_r[7:1]};
            end
         end
      end
   end

   // Frame ends after the idle gap [R1]
   always_ff @(posedge clk) begin
      if (srst) begin
         gapCyc_r <= 32'h0000_0000;
         seen_r <= 1'b0;
         rxGap <= 1'b0;
      end else begin
         rxGap <= 1'b0;
         if (rxBusy_r || !rxSync_r) begin
            gapCyc_r <= 32'h0000_0000;
         end else if (gapCyc_r != 32'(GAP_CYC - 1)) begin
            gapCyc_r <= gapCyc_r + 32'h0000_0001;
         end
         if (rxValid) begin
            seen_r <= 1'b1;
         end else if (seen_r && gapCyc_r == 32'(GAP_CYC - 1)) begin
            seen_r <= 1'b0;
            rxGap <= 1'b1;
         end
      end
   end
endmodule
`default_nettype wire

// ---- src/mmsp_master.sv ----
`default_nettype none
module mmsp_master #(
   parameter int BIT_CYC = mmsp_pkg::BIT_CYC,
   parameter int GAP_CYC = mmsp_pkg::GAP_CYC,
   parameter int TIMEOUT_CYC = mmsp_pkg::TIMEOUT_CYC
) (
   // System
   input wire logic clk,
   input wire logic srst,
   // Bus side
   mmsp_link_if.master link,
   // Software port
   input wire logic [4:0] swAddr,
   input wire logic [31:0] swWdata,
   input wire logic swWr,
   input wire logic swRd,
   output logic [31:0] swRdata
);
   import mmsp_pkg::*;
   typedef enum logic [1:0] {MS_IDLE, MS_LOAD, MS_WAIT, MS_REPLY} mmsp_mstate_t;
   mmsp_mstate_t st_r;
   logic txStart_r, txBusy, rxValid, rxGap, go, done_r, timeout_r, badReply_r, hdrBad_r;
   logic [7:0] txData_r, rxData, reqSlave_r, reqQty_r, byteNxt, rxCnt_r;
   logic [7:0] rb_r [4];
   logic [15:0] reqStart_r, txCrc_r, rxCrc_r;
   logic [2:0] seq_r;
   logic [31:0] waitCyc_r, status;

   mmsp_uart #(.BIT_CYC(BIT_CYC), .GAP_CYC(GAP_CYC)) uart (
      .clk(clk),
      .srst(srst),
      .rxPin(link.line),
      .txPin(link.mstTx),
      .txOeN(link.mstOeN),
      .txStart(txStart_r),
      .txData(txData_r),
      .txBusy(txBusy),
      .rxValid(rxValid),
      .rxData(rxData),
      .rxGap(rxGap)
   );

   assign go = swWr && swAddr == SW_GO && st_r == MS_IDLE;

   always_comb begin
      case (seq_r)
         3'h0: byteNxt = reqSlave_r;
         3'h1: byteNxt = FN_READ_HOLD;
         3'h2: byteNxt = reqStart_r[15:8];
         3'h3: byteNxt = reqStart_r[7:0];
         3'h4: byteNxt = 8'h00;
         3'h5: byteNxt = reqQty_r;
         3'h6: byteNxt = txCrc_r[7:0];
         default: byteNxt = txCrc_r[15:8];
      endcase
      status = 32'h0000_0000;
      status[ST_BUSY] = st_r != MS_IDLE;
      status[ST_DONE] = done_r;
      status[ST_TIMEOUT] = timeout_r;
      status[ST_BADREPLY] = badReply_r;
   end

   // Request setup is frozen while a transaction runs
   always_ff @(posedge clk) begin
      if (srst) begin
         reqSlave_r <= DEF_SLAVE;
         reqStart_r <= REG_PRESSURE;
         reqQty_r <= DEF_QTY;
      end else if (swWr && st_r == MS_IDLE) begin
         case (swAddr)
            SW_SLAVE: reqSlave_r <= swWdata[7:0];
            SW_START: reqStart_r <= swWdata[15:0];
            SW_QTY: reqQty_r <= swWdata[7:0];
            default: ;
         endcase
      end
   end

   always_ff @(posedge clk) begin
      if (srst) begin
         swRdata <= 32'h0000_0000;
      end else if (swRd) begin
         case (swAddr)
            SW_SLAVE: swRdata <= {24'h000000, reqSlave_r};
            SW_START: swRdata <= {16'h0000, reqStart_r};
            SW_QTY: swRdata <= {24'h000000, reqQty_r};
            SW_STATUS: swRdata <= status;
            SW_DATA_MSB: swRdata <= {rb_r[2], rb_r[3], rb_r[0], rb_r[1]}; // [R7]
            SW_DATA_LSB: swRdata <= {rb_r[1], rb_r[0], rb_r[3], rb_r[2]}; // [R8]
            default: swRdata <= 32'h0000_0000;
         endcase
      end else begin
         swRdata <= 32'h0000_0000;
      end
   end

   always_ff @(posedge clk) begin
      if (srst) begin
         st_r <= MS_IDLE;
         txStart_r <= 1'b0;
         txData_r <= 8'h00;
         txCrc_r <= CRC_INIT;
         rxCrc_r <= CRC_INIT;
         seq_r <= 3'h0;
         rxCnt_r <= 8'h00;
         waitCyc_r <= 32'h0000_0000;
         hdrBad_r <= 1'b0;
         done_r <= 1'b0;
         timeout_r <= 1'b0;
         badReply_r <= 1'b0;
         for (int i = 0; i < 4; i++)
            rb_r[i] <= 8'h00;
      end else begin
         txStart_r <= 1'b0;
         case (st_r)
            MS_IDLE: begin
               if (go) begin
                  done_r <= 1'b0;
                  timeout_r <= 1'b0;
                  badReply_r <= 1'b0;
                  seq_r <= 3'h0;
                  txCrc_r <= CRC_INIT;
                  st_r <= MS_LOAD;
               end
            end
            MS_LOAD: begin
               txStart_r <= 1'b1;
               txData_r <= byteNxt;
               if (seq_r < 3'h6)
                  txCrc_r <= crcStep(txCrc_r, byteNxt);
               st_r <= MS_WAIT;
            end
            MS_WAIT: begin
               if (!txStart_r && !txBusy) begin
                  seq_r <= seq_r + 3'h1;
                  st_r <= MS_LOAD;
                  if (seq_r == 3'h7) begin
                     st_r <= MS_REPLY;
                     waitCyc_r <= 32'h0000_0000;
                     rxCnt_r <= 8'h00;
                     rxCrc_r <= CRC_INIT;
                     hdrBad_r <= 1'b0;
                  end
               end
            end
            MS_REPLY: begin
               waitCyc_r <= waitCyc_r + 32'h0000_0001;
               if (rxValid && !txBusy) begin
                  if (rxCnt_r != 8'hFF)
                     rxCnt_r <= rxCnt_r + 8'h01;
                  if (rxCnt_r >= 8'(HEAD_LEN) && rxCnt_r < 8'(HEAD_LEN + 4))
                     rb_r[2'(rxCnt_r - 8'(HEAD_LEN))] <= rxData;
                  if ((rxCnt_r == 8'h00 && rxData != reqSlave_r) || (rxCnt_r == 8'h01 && rxData != FN_READ_HOLD))
                     hdrBad_r <= 1'b1;
                  rxCrc_r <= crcStep(rxCrc_r, rxData);
               end else if (rxGap && rxCnt_r != 8'h00) begin
                  st_r <= MS_IDLE;
                  if (rxCrc_r == CRC_RESIDUE && !hdrBad_r && rxCnt_r >= 8'(HEAD_LEN + 2))
                     done_r <= 1'b1;
                  else
                     badReply_r <= 1'b1;
               end else if (rxCnt_r == 8'h00 && waitCyc_r == 32'(TIMEOUT_CYC - 1)) begin
                  st_r <= MS_IDLE;
                  timeout_r <= 1'b1; // [R15]
               end
            end
            default: st_r <= MS_IDLE;
         endcase
      end
   end
endmodule
`default_nettype wire

// ---- sim/mmsp_link_checker.sv ----
`default_nettype none
module mmsp_link_checker #(
   parameter int PL = 40,
   parameter int PM = 20,
   parameter int PS = 10,
   parameter int BC = 1302
) (
   // System
   input wire logic clk,
   input wire logic srst,
   // Link
   input wire logic devTx,
   input wire logic devOeN,
   input wire logic mstTx,
   input wire logic mstOeN,
   // Pulse side
   input wire logic pulseSwitchOutput,
   input wire logic [15:0] flowM3s
);
   timeunit 1ns;
   timeprecision 1ps;
   logic [15:0] hiCnt_r;
   logic [15:0] devCnt_r;
   logic [15:0] expW;
   // Bench holds flow steady over a pulse, so width is judged at its end
   assign expW = (flowM3s > 16'h0006) ? 16'(PS) : ((flowM3s > 16'h0003) ? 16'(PM) : 16'(PL));
   always_ff @(posedge clk) begin
      hiCnt_r <= (srst || !pulseSwitchOutput) ? 16'h0000 : hiCnt_r + 16'h0001;
   end
   always_ff @(posedge clk) begin
      devCnt_r <= (srst || devOeN) ? 16'h0000 : devCnt_r + 16'h0001;
   end
   default clocking @(posedge clk); endclocking
   default disable iff (srst);
   a_no_bus_fight: assert property (devOeN || mstOeN)
      else $error("both ends drive the line");
   a_reset_quiet: assert property (disable iff (1'b0) srst |=> devOeN && mstOeN && !pulseSwitchOutput)
      else $error("outputs active after reset");
   a_dev_start_low: assert property ($fell(devOeN) |-> !devTx)
      else $error("meter byte without start bit");
   a_mst_start_low: assert property ($fell(mstOeN) |-> !mstTx)
      else $error("master byte without start bit");
   a_dev_stop_high: assert property ($rose(devOeN) |-> $past(devTx))
      else $error("meter released line without stop bit");
   a_dev_byte_len: assert property ($rose(devOeN) |-> devCnt_r >= 16'(9 * BC) && devCnt_r <= 16'(10 * BC + 2))
      else $error("meter drive time not one character");
   a_pulse_width: assert property ($fell(pulseSwitchOutput) |-> hiCnt_r == expW)
      else $error("pulse width wrong for flow");
   a_pulse_gap: assert property ($fell(pulseSwitchOutput) |=> !pulseSwitchOutput [*8])
      else $error("pulses run together");
   cover property ($rose(devOeN));
   cover property ($fell(mstOeN));
   cover property ($fell(pulseSwitchOutput) && hiCnt_r == 16'h000A);
endmodule
`default_nettype wire

// ---- sim/tb_top.sv ----
`default_nettype none
module tb_top;
   timeunit 1ns;
   timeprecision 1ps;
   import mmsp_pkg::*;
   logic clk = 1'b0;
   logic srst = 1'b1;
   logic [4:0] swAddr = 5'h00;
   logic [31:0] swWdata = 32'h0;
   logic swWr = 1'b0;
   logic swRd = 1'b0;
   logic [15:0] flowM3s = 16'h0;
   logic [15:0] volUnits = 16'h0;
   logic volValid = 1'b0;
   logic [3:0] serTens = 4'h4;
   logic [3:0] serOnes = 4'h2;
   logic [31:0] pressIn = 32'h3F800000;
   logic [31:0] flowIn = 32'h4148F5C3;
   // Shortened timing keeps whole frame exchanges inside the run budget
   localparam int BIT_T = 16;
   localparam int GAP_T = 300;
   localparam int SEC_T = 2000;
   localparam int PL_T = 40;
   localparam int PM_T = 20;
   localparam int PS_T = 10;
   localparam int TO_T = 6000;
   logic [31:0] swRdata;
   logic [31:0] totalCount;
   logic [31:0] rd;
   logic [7:0] slaveAddr;
   logic pulse;
   int n_errors = 0;
   int compares = 0;
   always #20 clk = ~clk;
   mmsp_link_if lnk();
   mmsp_meter #(.BIT_CYC(BIT_T), .GAP_CYC(GAP_T), .SECOND_CYC(SEC_T), .PULSE_LONG_CYC(PL_T), .PULSE_MID_CYC(PM_T),
      .PULSE_SHORT_CYC(PS_T)) i_mmsp_meter (.clk(clk), .srst(srst), .link(lnk), .serialTens(serTens),
      .serialOnes(serOnes), .pressureIn(pressIn), .flowIn(flowIn), .flowM3s(flowM3s),
      .volUnits(volUnits), .volValid(volValid), .pulseSwitchOutput(pulse), .slaveAddr(slaveAddr),
      .totalCount(totalCount));
   mmsp_master #(.BIT_CYC(BIT_T), .GAP_CYC(GAP_T), .TIMEOUT_CYC(TO_T)) i_mmsp_master (.clk(clk), .srst(srst),
      .link(lnk), .swAddr(swAddr), .swWdata(swWdata), .swWr(swWr), .swRd(swRd), .swRdata(swRdata));
   mmsp_link_checker #(.PL(PL_T), .PM(PM_T), .PS(PS_T), .BC(BIT_T)) i_chk (.clk(clk), .srst(srst), .devTx(lnk.devTx),
      .devOeN(lnk.devOeN), .mstTx(lnk.mstTx), .mstOeN(lnk.mstOeN), .pulseSwitchOutput(pulse),
      .flowM3s(flowM3s));
   task automatic chk(input logic [31:0] got, input logic [31:0] exp, input string what);
      compares++;
      if (got !== exp) begin
         n_errors++;
         $display("[ERR] %0t %s got %h exp %h", $time, what, got, exp);
      end
   endtask
   task automatic complete_run;
      $display("compares %0d errors %0d", compares, n_errors);
      if (n_errors == 0 && compares > 0) begin
         $display("NO MISMATCHES");
      end else begin
         $display("MISMATCHES SEEN");
      end
      $finish;
   endtask
   task automatic swWrite(input logic [4:0] a, input logic [31:0] d);
      @(posedge clk);
      swAddr <= a;
      swWdata <= d;
      swWr <= 1'b1;
      @(posedge clk);
      swWr <= 1'b0;
   endtask
   task automatic swRead(input logic [4:0] a, output logic [31:0] d);
      @(posedge clk);
      swAddr <= a;
      swRd <= 1'b1;
      @(posedge clk);
      swRd <= 1'b0;
      #1 d = swRdata;
   endtask
   // Poll bound covers request plus a full reply timeout
   task automatic transact(input logic [7:0] sa, input logic [15:0] sr, input logic [7:0] q);
      swWrite(SW_SLAVE, {24'h0, sa});
      swWrite(SW_START, {16'h0, sr});
      swWrite(SW_QTY, {24'h0, q});
      swWrite(SW_GO, 32'h0);
      for (int i = 0; i < 15000; i++) begin
         swRead(SW_STATUS, rd);
         if (rd[ST_BUSY] === 1'b0) return;
      end
      n_errors++;
      $display("[ERR] %0t transaction hung", $time);
      complete_run;
   endtask
   task automatic pulseRun(input logic [15:0] f, input int w);
      int rises = 0;
      int hi = 0;
      logic prev = 1'b0;
      @(posedge clk);
      flowM3s <= f;
      volUnits <= 16'h0002;
      volValid <= 1'b1;
      @(posedge clk);
      volValid <= 1'b0;
      repeat (4100 + 4 * w) begin
         @(posedge clk);
         #1;
         if (pulse === 1'b1 && prev !== 1'b1) rises++;
         if (pulse === 1'b1) hi++;
         prev = pulse;
      end
      chk(32'(rises), 32'h2, "pulse count");
      chk(32'(hi), 32'(2 * w), "pulse width");
   endtask
   initial begin
      repeat (2) @(posedge clk);
      srst <= 1'b0;
      repeat (3) @(posedge clk);
      swRead(SW_STATUS, rd);
      chk(rd, 32'h0, "status reset");
      swRead(SW_SLAVE, rd);
      chk(rd, 32'h1, "slave reset");
      swRead(5'h1C, rd);
      chk(rd, 32'h0, "unmapped read");
      chk({24'h0, slaveAddr}, 32'h2A, "slave address");
      $display("test registers done");
      pulseRun(16'h0003, 40);
      pulseRun(16'h0004, 20);
      pulseRun(16'h0007, 10);
      chk(totalCount, 32'h6, "consumption total");
      $display("test pulses done");
      transact(8'h2A, REG_FLOW, 8'h02);
      chk(rd, 32'h2, "reply done");
      swRead(SW_DATA_MSB, rd);
      chk(rd, 32'h4148F5C3, "big endian image");
      swRead(SW_DATA_LSB, rd);
      chk(rd, 32'hC3F54841, "little endian image");
      $display("test flow read done");
      transact(8'h2A, REG_PRESSURE, 8'h02);
      chk(rd, 32'h2, "pressure reply done");
      swRead(SW_DATA_MSB, rd);
      chk(rd, 32'h3F800000, "pressure image");
      transact(8'h2A, REG_CONSUMPTION, 8'h02);
      chk(rd, 32'h2, "consumption reply done");
      swRead(SW_DATA_MSB, rd);
      chk(rd, 32'h6, "consumption image");
      swRead(SW_DATA_LSB, rd);
      chk(rd, 32'h06000000, "consumption little endian");
      $display("test channel reads done");
      transact(8'h2B, REG_FLOW, 8'h02);
      chk(rd, 32'h4, "foreign address timeout");
      transact(8'h2A, REG_FLOW, 8'h00);
      chk(rd, 32'h4, "zero quantity timeout");
      $display("test refused requests done");
      complete_run;
   end
endmodule
`default_nettype wire
